// File: fpre_pkg.sv
/*
  fpre_pkg: constants and types for the flash protect and ram emulation block.
  assumes an apb slave port with 32-bit data and a byte address of 16 bits.
*/
package fpre_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [31:0] FAULT_STAT_IDX = 32'hffff8581;
  localparam logic [31:0] ERASE_EN_IDX = 32'hffff8582;
  localparam logic [31:0] EMU_CTRL_IDX = 32'hffff8628;
  localparam logic [31:0] IRQ_STAT_IDX = 32'hffff8700;
  localparam logic [31:0] IRQ_MASK_IDX = 32'hffff8701;

  // field positions
  localparam int FAULT_BIT = 7;
  localparam int EMU_SEL_BIT = 2;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_EMU_BIT = 1;

  // values after reset
  localparam logic [7:0] ERASE_EN_RST = 8'h00;
  localparam logic [2:0] EMU_CTRL_RST = 3'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // address map of the 1 kB ram window
  localparam logic [23:0] RAM_HOME_BASE = 24'hfff800;
  localparam logic [23:0] OVERLAY_BASE = 24'h01f000;
  localparam logic [23:0] WINDOW_SIZE = 24'h000400;

  // first flash block that the overlay can cover
  localparam int OVERLAY_FIRST_BLK = 4;

  // apb answer latency in cycles from the access phase start
  localparam int APB_WAIT_CYCLES = 1;

  // emulation control carried as one bundle
  typedef struct packed {
    logic emulation_select;
    logic overlay_block_sel_hi;
    logic overlay_block_sel_lo;
  } fpre_emu_t;

  // apb slave handshake states
  typedef enum logic [1:0] {
    FPRE_IDLE = 2'b00,
    FPRE_ACK = 2'b01
  } fpre_state_t;

endpackage

// File: fpre_top.sv
/*
  fpre_top: software view of flash protection and ram emulation, apb slave.
  assumes i_pe_fault comes from the flash sequencer on i_clock, one cycle per fault,
  and that i_rst_b is the power-on reset of the device.
*/
// The APB register port was decided locally.
// Notes on behaviour
// - fault flag reads 0 normally; only power-on reset clears it; lockout off.
// - a program or erase fault sets the flag and blocks further program and erase.
// - eight erase enable bits, one per block; 0 protects, 1 allows erase.
// - emulation select 0 means no overlay and no emulation protection.
// - emulation select 1 overlays ram and protects all blocks while set.
// - overlay base by block select: home window, or one of four 1 kB blocks.
`timescale 1ns/1ps

module fpre_top #(
  parameter int ADDR_W = 16,
  parameter int NUM_BLK = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic i_pe_fault,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_prog_lock,
  output logic [NUM_BLK-1:0] o_erase_allow,
  output logic o_emu_active,
  output logic [23:0] o_ram_base,
  output logic o_irq
);

  // register decode on the word index; used by read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [31:0] idx);
    hit = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
  endfunction

  fpre_pkg::fpre_state_t state_ff;
  fpre_pkg::fpre_state_t nxt_state;
  fpre_pkg::fpre_emu_t emu_ff;
  logic fault_ff;
  logic [NUM_BLK-1:0] erase_en_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic prog_lock_ff;
  logic [NUM_BLK-1:0] erase_allow_ff;
  logic emu_active_ff;
  logic [23:0] ram_base_ff;
  logic irq_ff;
  logic mapped;
  logic wr_done;
  logic rd_done;
  logic lock_now;
  logic [2:0] emu_wr;
  logic [1:0] irq_set;
  logic [31:0] nxt_prdata;
  logic [23:0] nxt_ram_base;
  logic [1:0] nxt_irq_stat;
  logic stat_rd;
  logic ers_wr;
  logic emu_wr_en;

  // address is one of ours
  assign mapped = hit(i_paddr, fpre_pkg::FAULT_STAT_IDX) |
                  hit(i_paddr, fpre_pkg::ERASE_EN_IDX) |
                  hit(i_paddr, fpre_pkg::EMU_CTRL_IDX) |
                  hit(i_paddr, fpre_pkg::IRQ_STAT_IDX) |
                  hit(i_paddr, fpre_pkg::IRQ_MASK_IDX);

  // transfer completes at the edge where pready is high
  assign wr_done = i_psel & i_penable & pready_ff & i_pwrite & mapped;
  assign rd_done = i_psel & i_penable & pready_ff & ~i_pwrite & mapped;

  // strobes named once so the checks below see the same decode as the logic
  assign stat_rd = rd_done & hit(i_paddr, fpre_pkg::IRQ_STAT_IDX);
  assign ers_wr = wr_done & i_pstrb[0] & hit(i_paddr, fpre_pkg::ERASE_EN_IDX);
  assign emu_wr_en = wr_done & i_pstrb[0] & hit(i_paddr, fpre_pkg::EMU_CTRL_IDX);

  // apb handshake: one wait state gives registered ready and data
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      fpre_pkg::FPRE_IDLE:
      begin
        if (i_psel & i_penable)
          nxt_state = fpre_pkg::FPRE_ACK;
      end
      fpre_pkg::FPRE_ACK:
      begin
        nxt_state = fpre_pkg::FPRE_IDLE;
      end
      default:
      begin
        nxt_state = fpre_pkg::FPRE_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_ff <= fpre_pkg::FPRE_IDLE;
    else
      state_ff <= nxt_state;
  end

  // ready and error are presented for exactly one cycle
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= (nxt_state == fpre_pkg::FPRE_ACK);
      pslverr_ff <= (nxt_state == fpre_pkg::FPRE_ACK) & ~mapped;
    end
  end

  // read mux; reserved bits read as zero
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    if (hit(i_paddr, fpre_pkg::FAULT_STAT_IDX))
      nxt_prdata[fpre_pkg::FAULT_BIT] = fault_ff;
    if (hit(i_paddr, fpre_pkg::ERASE_EN_IDX))
      nxt_prdata[NUM_BLK-1:0] = erase_en_ff;
    if (hit(i_paddr, fpre_pkg::EMU_CTRL_IDX))
      nxt_prdata[2:0] = emu_ff;
    if (hit(i_paddr, fpre_pkg::IRQ_STAT_IDX))
      nxt_prdata[1:0] = irq_stat_ff;
    if (hit(i_paddr, fpre_pkg::IRQ_MASK_IDX))
      nxt_prdata[1:0] = irq_mask_ff;
  end

  // read data is captured as ready rises and held until the next read access; writes leave it
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      prdata_ff <= 32'h0000_0000;
    else if (nxt_state == fpre_pkg::FPRE_ACK && !i_pwrite)
      prdata_ff <= nxt_prdata;
  end

  // fault flag is sticky; no write path, only power-on reset clears it
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      fault_ff <= 1'b0;
    else if (i_pe_fault)
      fault_ff <= 1'b1;
  end

  // erase enables; low lane carries all eight bits
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      erase_en_ff <= fpre_pkg::ERASE_EN_RST;
    else if (wr_done && i_pstrb[0] && hit(i_paddr, fpre_pkg::ERASE_EN_IDX))
      erase_en_ff <= i_pwdata[NUM_BLK-1:0];
  end

  // only bits 2:0 of the emulation control are writable
  assign emu_wr = i_pwdata[2:0];

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      emu_ff <= fpre_pkg::EMU_CTRL_RST;
    else if (wr_done && i_pstrb[0] && hit(i_paddr, fpre_pkg::EMU_CTRL_IDX))
      emu_ff <= emu_wr;
  end

  // events: a new fault, and emulation switching on
  assign irq_set[fpre_pkg::IRQ_FAULT_BIT] = i_pe_fault & ~fault_ff;
  assign irq_set[fpre_pkg::IRQ_EMU_BIT] = wr_done & i_pstrb[0] &
    hit(i_paddr, fpre_pkg::EMU_CTRL_IDX) & emu_wr[fpre_pkg::EMU_SEL_BIT] &
    ~emu_ff.emulation_select;

  // a read clears only the bits that it reported: an event that lands after the data
  // was captured survives, and an event in the clearing cycle always wins
  always_comb
  begin
    nxt_irq_stat = irq_stat_ff | irq_set;
    if (stat_rd)
      nxt_irq_stat = (irq_stat_ff & ~prdata_ff[1:0]) | irq_set;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      irq_stat_ff <= fpre_pkg::IRQ_RST;
    else
      irq_stat_ff <= nxt_irq_stat;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      irq_mask_ff <= fpre_pkg::IRQ_RST;
    else if (wr_done && i_pstrb[0] && hit(i_paddr, fpre_pkg::IRQ_MASK_IDX))
      irq_mask_ff <= i_pwdata[1:0];
  end

  // level interrupt from the next-state status so it tracks the register
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
  end

  // lockout from either cause; uses next flag value so no fault slips a cycle
  assign lock_now = fault_ff | i_pe_fault | emu_ff.emulation_select;

  // overlay base: home window when off, selected 1 kB block when on
  always_comb
  begin
    nxt_ram_base = fpre_pkg::RAM_HOME_BASE;
    if (emu_ff.emulation_select)
      nxt_ram_base = fpre_pkg::OVERLAY_BASE + fpre_pkg::WINDOW_SIZE *
        {22'h0, emu_ff.overlay_block_sel_hi, emu_ff.overlay_block_sel_lo};
  end

  // block outputs, all registered
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      prog_lock_ff <= 1'b0;
      erase_allow_ff <= '0;
      emu_active_ff <= 1'b0;
      ram_base_ff <= fpre_pkg::RAM_HOME_BASE;
    end
    else
    begin
      prog_lock_ff <= lock_now;
      erase_allow_ff <= erase_en_ff & {NUM_BLK{~lock_now}};
      emu_active_ff <= emu_ff.emulation_select;
      ram_base_ff <= nxt_ram_base;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_prog_lock = prog_lock_ff;
  assign o_erase_allow = erase_allow_ff;
  assign o_emu_active = emu_active_ff;
  assign o_ram_base = ram_base_ff;
  assign o_irq = irq_ff;

  // checks kept beside the logic

  sequence fault_seen_s;
    i_pe_fault;
  endsequence

  sequence locked_after_s;
    ##1 (fault_ff && o_prog_lock && o_erase_allow == '0) ##1 o_prog_lock;
  endsequence

  sequence stat_read_s;
    stat_rd;
  endsequence

  fault_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !fault_ff && !i_pe_fault && !emu_ff.emulation_select |=> !o_prog_lock)
    else $error("lockout without fault or emulation");

  fault_sticky_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    fault_ff |=> fault_ff)
    else $error("fault flag cleared without reset");

  fault_lock_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    fault_seen_s |-> locked_after_s)
    else $error("fault did not lock program and erase");

  erase_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !fault_ff && !i_pe_fault && !emu_ff.emulation_select |=> o_erase_allow == $past(erase_en_ff))
    else $error("erase enable not passed through");

  emu_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !emu_ff.emulation_select |=> !o_emu_active && o_ram_base == fpre_pkg::RAM_HOME_BASE)
    else $error("overlay active while deselected");

  emu_protect_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    emu_ff.emulation_select [*2] |-> o_prog_lock && o_erase_allow == '0)
    else $error("flash writable during emulation");

  overlay_base_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    emu_ff == 3'b111 |=> o_ram_base == 24'h01fc00)
    else $error("overlay base wrong for last block");

  apb_answer_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_psel && i_penable && !o_pready |-> ##1 o_pready)
    else $error("apb answer late");

  ready_pulse_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_pready |=> !o_pready)
    else $error("ready held beyond one cycle");

  slverr_ready_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_pslverr |-> o_pready)
    else $error("error flagged without ready");

  stat_set_wins_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    irq_set != 2'h0 |=> (irq_stat_ff & $past(irq_set)) == $past(irq_set))
    else $error("status event lost");

  stat_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    stat_read_s |=> (irq_stat_ff & $past(prdata_ff[1:0]) & ~$past(irq_set)) == 2'h0)
    else $error("reported status bit not cleared by read");

  fault_irq_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_pe_fault && !fault_ff |=> irq_stat_ff[fpre_pkg::IRQ_FAULT_BIT])
    else $error("first fault raised no status bit");

  irq_level_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    1'b1 |=> o_irq == (|(irq_stat_ff & $past(irq_mask_ff))))
    else $error("interrupt level does not follow status and mask");

  erase_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !ers_wr |=> $stable(erase_en_ff))
    else $error("erase enables changed without a write");

  emu_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !emu_wr_en |=> $stable(emu_ff))
    else $error("emulation control changed without a write");

  overlay_first_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    emu_ff == 3'b100 |=> o_ram_base == fpre_pkg::OVERLAY_BASE)
    else $error("overlay base wrong for first block");

endmodule

// File: fpre_tb.sv
/*
  tb: self-checking bench for fpre_top, driven over apb.
  assumes the package address map, a 125 MHz clock and one-cycle fault pulses.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; \
  $display("[FAIL] %s exp=%h got=%h", nm, ex, got); end end

module tb;
  localparam logic [15:0] A_FLT = {fpre_pkg::FAULT_STAT_IDX[13:0], 2'b00};
  localparam logic [15:0] A_ERS = {fpre_pkg::ERASE_EN_IDX[13:0], 2'b00};
  localparam logic [15:0] A_EMU = {fpre_pkg::EMU_CTRL_IDX[13:0], 2'b00};
  localparam logic [15:0] A_IST = {fpre_pkg::IRQ_STAT_IDX[13:0], 2'b00};
  localparam logic [15:0] A_IMK = {fpre_pkg::IRQ_MASK_IDX[13:0], 2'b00};
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [15:0] i_paddr = 16'h0000;
  logic [31:0] i_pwdata = 32'h00000000;
  logic [3:0] i_pstrb = 4'hf;
  logic i_pe_fault = 1'b0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_prog_lock, o_emu_active, o_irq;
  logic [7:0] o_erase_allow;
  logic [23:0] o_ram_base;
  int n_errors = 0;
  int checked = 0;
  logic [34:0] exp_q[$]; // kind, slverr, data
  logic [34:0] e;
  logic [31:0] d;
  logic [23:0] b;

  fpre_top fpre_top_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .i_pe_fault(i_pe_fault),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prog_lock(o_prog_lock),
    .o_erase_allow(o_erase_allow), .o_emu_active(o_emu_active), .o_ram_base(o_ram_base), .o_irq(o_irq));

  // 8 ns clock
  always #4 i_clock = ~i_clock;

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer; kind 0 checks the error only, 1 also the data, 2 nothing
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd, input logic [3:0] st,
                     input logic [1:0] kind, input logic err, input logic [31:0] ed);
    int n;
    exp_q.push_back({kind, err, ed});
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_paddr <= a;
    i_pwrite <= wr;
    i_pwdata <= wd;
    i_pstrb <= st;
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (o_pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      tally_and_finish();
    end
    else
    begin
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 4'hf, 2'd0, 1'b0, 32'h0);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed);
    apb(1'b0, a, 32'h0, 4'h0, 2'd1, 1'b0, ed);
  endtask

  // levels settle within two edges of their cause
  task automatic lv(input logic lk, input logic [7:0] al, input logic em, input logic [23:0] rb, input logic iq);
    repeat (2) @(posedge i_clock);
    `CHK("prog_lock", lk, o_prog_lock)
    `CHK("erase_allow", al, o_erase_allow)
    `CHK("emu_active", em, o_emu_active)
    `CHK("ram_base", rb, o_ram_base)
    `CHK("irq", iq, o_irq)
  endtask

  task automatic fault();
    @(posedge i_clock);
    i_pe_fault <= 1'b1;
    @(posedge i_clock);
    i_pe_fault <= 1'b0;
  endtask

  // answer watcher: oldest note is compared when pready is seen
  always @(posedge i_clock)
  begin
    if (o_pready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e[34:33] != 2'd2)
        `CHK("pslverr", e[32], o_pslverr)
      if (e[34:33] == 2'd1)
        `CHK("prdata", e[31:0], o_prdata)
    end
  end

  initial
  begin
    void'($urandom(82));
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    lv(1'b0, 8'h00, 1'b0, 24'hfff800, 1'b0);
    rd(A_FLT, 32'h0);
    rd(A_ERS, 32'h0);
    rd(A_EMU, 32'h0);
    rd(A_IST, 32'h0);
    rd(A_IMK, 32'h0);
    // erase enables with random data, last one all set
    for (int k = 0; k < 4; k++)
    begin
      d = (k == 3) ? 32'hffffffff : $urandom;
      wr(A_ERS, d);
      rd(A_ERS, {24'h0, d[7:0]});
      lv(1'b0, d[7:0], 1'b0, 24'hfff800, 1'b0);
    end
    // disabled lane and unmapped place leave state alone
    apb(1'b1, A_ERS, 32'h0, 4'h0, 2'd0, 1'b0, 32'h0);
    rd(A_ERS, 32'hff);
    apb(1'b1, 16'h0000, $urandom, 4'hf, 2'd0, 1'b1, 32'h0);
    apb(1'b0, 16'h0000, 32'h0, 4'h0, 2'd1, 1'b1, 32'h0);
    // every emulation select and block select value
    for (int s = 0; s < 8; s++)
    begin
      d = $urandom;
      wr(A_EMU, {d[31:3], 3'(s)});
      rd(A_EMU, {29'h0, 3'(s)});
      b = s[2] ? fpre_pkg::OVERLAY_BASE + 24'(s[1:0]) * fpre_pkg::WINDOW_SIZE : 24'hfff800;
      lv(s[2], s[2] ? 8'h00 : 8'hff, s[2], b, 1'b0);
    end
    rd(A_IST, 32'h2);
    rd(A_IST, 32'h0);
    wr(A_EMU, 32'h0);
    wr(A_IMK, 32'h1);
    lv(1'b0, 8'hff, 1'b0, 24'hfff800, 1'b0);
    // fault sets the flag, locks out and interrupts once
    fault();
    lv(1'b1, 8'h00, 1'b0, 24'hfff800, 1'b1);
    rd(A_FLT, 32'h80);
    apb(1'b1, A_FLT, 32'h0, 4'hf, 2'd2, 1'b0, 32'h0);
    rd(A_FLT, 32'h80);
    rd(A_IST, 32'h1);
    lv(1'b1, 8'h00, 1'b0, 24'hfff800, 1'b0);
    fault();
    lv(1'b1, 8'h00, 1'b0, 24'hfff800, 1'b0);
    rd(A_IST, 32'h0);
    rd(A_ERS, 32'hff);
    wr(A_IMK, 32'h3);
    wr(A_EMU, 32'h4);
    lv(1'b1, 8'h00, 1'b1, 24'h01f000, 1'b1);
    rd(A_IST, 32'h2);
    // only reset clears the flag
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    lv(1'b0, 8'h00, 1'b0, 24'hfff800, 1'b0);
    rd(A_FLT, 32'h0);
    rd(A_EMU, 32'h0);
    // a fault during a status read is not lost to the clear
    wr(A_IMK, 32'h1);
    fork
      rd(A_IST, 32'h0);
      begin
        repeat (2) @(posedge i_clock);
        i_pe_fault <= 1'b1;
        @(posedge i_clock);
        i_pe_fault <= 1'b0;
      end
    join
    lv(1'b1, 8'h00, 1'b0, 24'hfff800, 1'b1);
    rd(A_IST, 32'h1);
    lv(1'b1, 8'h00, 1'b0, 24'hfff800, 1'b0);
    repeat (2) @(posedge i_clock);
    `CHK("queue", 0, exp_q.size())
    tally_and_finish();
  end
endmodule
